// ==== logic/bmrs_top.sv ====
// Address range select, cycle strobes and bipolar matrix access
//
// Notes on behaviour
// - Matrix holds four rows of 256 words
// - Word is 18 bits with parity, else 16
// - Address bits 10..9 pick one of the four rows
// - After chip select, assert byte write strobes
// - Write only selected circuits while strobes asserted
// - DATI reads addressed word onto sense lines
// - Refresh enabled only for MOS strap
// - Access memory only when bits 17..11 match, 17..13 with MOS strap
// - Bits 17..16 section, bit 15 group
// - Bits 14..13 place MOS module or 4K block
// - Bits 12..11 assign bipolar 1K quarters
// - Return low-active range hit to processor
// - Hit is AND of nine terms
// - Bit matches 0 with strap, 1 without
// - Module term true unless strapped and in range
// - Word write: both strobes, each fanned twice
// - Third select per row from chip select
`timescale 1ns/10ps
`default_nettype none
module bmrs_top #(
  parameter bit PARITY = 1'b1
) (
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_resetn,
  input  wire logic                          i_cycle_req,
  input  wire logic                          i_dato,
  input  wire logic                          i_byte,
  input  wire logic [bmrs_pkg::ADDR_W-1:0]   i_bus_addr,
  input  wire logic [bmrs_pkg::DATA_W_PARITY-1:0] i_wdata,
  input  wire logic [bmrs_pkg::RANGE_BITS-1:0] i_range_strap,
  input  wire logic [bmrs_pkg::MOD_TERMS-1:0] i_module_strap,
  input  wire logic                          i_mos_strap,
  output logic                               o_range_hit_n,
  output logic                               o_chip_select_strobe_n,
  output logic                               o_low_byte_write_strobe_n,
  output logic                               o_high_byte_write_strobe_n,
  output logic                               o_refresh_enable,
  output logic                               o_cycle_done,
  output logic [bmrs_pkg::DATA_W_PARITY-1:0] o_sense_data
);
  import bmrs_pkg::*;

  localparam int unsigned DATA_W = PARITY ? DATA_W_PARITY : DATA_W_PLAIN;

  typedef struct packed {
    logic [1:0]               req_s;
    logic [1:0]               dato_s;
    logic [1:0]               byte_s;
    logic [1:0]               mos_s;
    logic [ADDR_W-1:0]        addr_s1;
    logic [ADDR_W-1:0]        addr_s2;
    logic [DATA_W_PARITY-1:0] data_s1;
    logic [DATA_W_PARITY-1:0] data_s2;
    logic [RANGE_BITS-1:0]    rstrap_s1;
    logic [RANGE_BITS-1:0]    rstrap_s2;
    logic [MOD_TERMS-1:0]     mstrap_s1;
    logic [MOD_TERMS-1:0]     mstrap_s2;
    bmrs_state_t              state;
    logic [1:0]               cnt;
    logic [ADDR_W-1:0]        addr;
    logic [DATA_W_PARITY-1:0] wdata;
    logic                     dato;
    logic                     bmode;
    logic                     hit;
    logic                     cs_n;
    logic                     wlo_n;
    logic                     whi_n;
    logic                     done;
    logic [DATA_W_PARITY-1:0] rdata;
  } bmrs_regs_t;

  bmrs_regs_t r_q;
  bmrs_regs_t r_d;

  bmrs_mem_if #(.DATA_W(DATA_W)) mif ();

  logic [RANGE_BITS-1:0] range_ok;
  logic [MOD_TERMS-1:0]  mod_ok;
  logic [1:0]            mod_field;
  logic                  hit_now;
  logic [ROW_W-1:0]      row;
  logic                  board_enable;

  // Range compare on the latched address, so the hit cannot glitch mid-cycle
  always_comb begin
    for (int b = 0; b < int'(RANGE_BITS); b++) begin
      // Strap present accepts a 0 bit, strap removed accepts a 1 bit
      range_ok[b] = r_q.addr[RANGE_LSB+b] ^ r_q.rstrap_s2[b];
    end
    // MOS modules are steered by bits 14..13, so the block compare covers only 17..15
    if (r_q.mos_s[1]) begin
      range_ok[1:0] = 2'h3;
      mod_field     = r_q.addr[MOD_LSB_MOS +: 2];
    end else begin
      mod_field     = r_q.addr[MOD_LSB_BIP +: 2];
    end
    for (int m = 0; m < int'(MOD_TERMS); m++) begin
      mod_ok[m] = ~r_q.mstrap_s2[m] | (mod_field != 2'(m));
    end
    hit_now = &{range_ok, mod_ok};
  end

  assign board_enable = r_q.hit;
  assign row          = r_q.addr[ROW_LSB +: ROW_W];

  for (genvar k = 0; k < ROWS; k++) begin : g_rowsel
    assign mif.row_select_first_n[k]  = ~(board_enable && row == ROW_W'(k));
    assign mif.row_select_second_n[k] = ~(board_enable && row == ROW_W'(k));
    assign mif.row_strobe_third_n[k]  = r_q.cs_n;
  end

  assign mif.col                  = r_q.addr[COL_LSB +: COL_W];
  assign mif.wdata                = r_q.wdata[DATA_W-1:0];
  assign mif.low_byte_wr_out_a_n  = r_q.wlo_n;
  assign mif.low_byte_wr_out_b_n  = r_q.wlo_n;
  assign mif.high_byte_wr_out_a_n = r_q.whi_n;
  assign mif.high_byte_wr_out_b_n = r_q.whi_n;

  bmrs_matrix #(
    .DATA_W (DATA_W)
  ) u_matrix (
    .i_clk_sys (i_clk_sys),
    .mem       (mif.mem)
  );

  always_comb begin
    r_d           = r_q;
    r_d.req_s     = {r_q.req_s[0], i_cycle_req};
    r_d.dato_s    = {r_q.dato_s[0], i_dato};
    r_d.byte_s    = {r_q.byte_s[0], i_byte};
    r_d.mos_s     = {r_q.mos_s[0], i_mos_strap};
    r_d.addr_s1   = i_bus_addr;
    r_d.addr_s2   = r_q.addr_s1;
    r_d.data_s1   = i_wdata;
    r_d.data_s2   = r_q.data_s1;
    r_d.rstrap_s1 = i_range_strap;
    r_d.rstrap_s2 = r_q.rstrap_s1;
    r_d.mstrap_s1 = i_module_strap;
    r_d.mstrap_s2 = r_q.mstrap_s1;
    r_d.done      = 1'b0;
    case (r_q.state)
      BMRS_IDLE: begin
        r_d.hit = 1'b0;
        if (r_q.req_s[1]) begin
          // Address and data are frozen here for the whole cycle
          r_d.addr  = r_q.addr_s2;
          r_d.wdata = r_q.data_s2;
          r_d.dato  = r_q.dato_s[1];
          r_d.bmode = r_q.byte_s[1];
          r_d.state = BMRS_SELECT;
        end
      end
      BMRS_SELECT: begin
        r_d.hit = hit_now;
        if (hit_now) begin
          r_d.cs_n  = 1'b0;
          r_d.cnt   = SETUP_CNT;
          r_d.state = r_q.dato ? BMRS_WRITE : BMRS_READ;
        end else begin
          r_d.state = BMRS_DONE;
        end
      end
      BMRS_WRITE: begin
        if (r_q.cnt > 2'h1) begin
          r_d.cnt = r_q.cnt - 2'h1;
        end else if (r_q.wlo_n && r_q.whi_n) begin
          // Byte writes pick a half by address bit 0, word writes both
          r_d.wlo_n = r_q.bmode && r_q.addr[BYTE_BIT];
          r_d.whi_n = r_q.bmode && !r_q.addr[BYTE_BIT];
        end else begin
          r_d.wlo_n = STROBE_IDLE_N;
          r_d.whi_n = STROBE_IDLE_N;
          r_d.state = BMRS_DONE;
        end
      end
      BMRS_READ: begin
        // Matrix register holds the word one edge after chip select
        if (r_q.cnt > 2'h0) begin
          r_d.cnt = r_q.cnt - 2'h1;
        end else begin
          r_d.rdata = '0;
          r_d.rdata[DATA_W-1:0] = mif.sense_data;
          r_d.state = BMRS_DONE;
        end
      end
      BMRS_DONE: begin
        r_d.cs_n = STROBE_IDLE_N;
        if (!r_q.req_s[1]) begin
          r_d.done  = 1'b1;
          r_d.hit   = 1'b0;
          r_d.state = BMRS_IDLE;
        end
      end
      default: begin
        r_d.state = BMRS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      r_q       <= '0;
      r_q.req_s <= SYNC_RST;
      r_q.state <= BMRS_IDLE;
      r_q.cs_n  <= STROBE_IDLE_N;
      r_q.wlo_n <= STROBE_IDLE_N;
      r_q.whi_n <= STROBE_IDLE_N;
    end else begin
      r_q <= r_d;
    end
  end

  assign o_range_hit_n              = ~r_q.hit;
  assign o_chip_select_strobe_n     = r_q.cs_n;
  assign o_low_byte_write_strobe_n  = r_q.wlo_n;
  assign o_high_byte_write_strobe_n = r_q.whi_n;
  assign o_refresh_enable           = r_q.mos_s[1];
  assign o_cycle_done               = r_q.done;
  assign o_sense_data               = r_q.rdata;
endmodule : bmrs_top
`default_nettype wire

// ==== logic/bmrs_pkg.sv ====
// Constants and types shared by the range select and matrix logic
package bmrs_pkg;
  localparam int unsigned ADDR_W        = 18;
  localparam int unsigned DATA_W_PARITY = 18;
  localparam int unsigned DATA_W_PLAIN  = 16;
  localparam int unsigned ROWS          = 4;
  localparam int unsigned ROW_WORDS     = 256;
  localparam int unsigned ROW_W         = 2;
  localparam int unsigned COL_W         = 8;
  localparam int unsigned RANGE_BITS    = 5;
  localparam int unsigned MOD_TERMS     = 4;
  // Bus address bit positions
  localparam int unsigned RANGE_LSB     = 13;
  localparam int unsigned MOD_LSB_BIP   = 11;
  localparam int unsigned MOD_LSB_MOS   = 13;
  localparam int unsigned ROW_LSB       = 9;
  localparam int unsigned COL_LSB       = 1;
  localparam int unsigned BYTE_BIT      = 0;
  // Reset values
  localparam logic [1:0]  SYNC_RST      = 2'h0;
  localparam logic        STROBE_IDLE_N = 1'h1;
  // Cycles the chip select leads the write strobes
  localparam int unsigned SETUP_CYCLES  = 1;
  localparam logic [1:0]  SETUP_CNT     = 2'(SETUP_CYCLES);

  typedef enum logic [2:0] {
    BMRS_IDLE   = 3'b000,
    BMRS_SELECT = 3'b001,
    BMRS_WRITE  = 3'b010,
    BMRS_READ   = 3'b011,
    BMRS_DONE   = 3'b100
  } bmrs_state_t;
endpackage : bmrs_pkg

// ==== logic/bmrs_mem_if.sv ====
// Signals between the control and the bipolar storage matrix
`timescale 1ns/10ps
`default_nettype none
interface bmrs_mem_if #(
  parameter int unsigned DATA_W = 18
);
  logic [3:0]        row_select_first_n;
  logic [3:0]        row_select_second_n;
  logic [3:0]        row_strobe_third_n;
  logic [7:0]        col;
  logic              low_byte_wr_out_a_n;
  logic              low_byte_wr_out_b_n;
  logic              high_byte_wr_out_a_n;
  logic              high_byte_wr_out_b_n;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] sense_data;

  modport ctrl (
    output row_select_first_n, row_select_second_n, row_strobe_third_n, col,
    output low_byte_wr_out_a_n, low_byte_wr_out_b_n,
    output high_byte_wr_out_a_n, high_byte_wr_out_b_n, wdata,
    input  sense_data
  );
  modport mem (
    input  row_select_first_n, row_select_second_n, row_strobe_third_n, col,
    input  low_byte_wr_out_a_n, low_byte_wr_out_b_n,
    input  high_byte_wr_out_a_n, high_byte_wr_out_b_n, wdata,
    output sense_data
  );
endinterface : bmrs_mem_if
`default_nettype wire

// ==== logic/bmrs_matrix.sv ====
// Bipolar storage matrix: four rows of 256 words with byte writes
`timescale 1ns/10ps
`default_nettype none
module bmrs_matrix #(
  parameter int unsigned DATA_W = 18
) (
  input  wire logic i_clk_sys,
  bmrs_mem_if.mem   mem
);
  import bmrs_pkg::*;

  localparam int unsigned LO_W = DATA_W / 2;

  logic [DATA_W-1:0] words [ROWS*ROW_WORDS];
  logic [ROWS-1:0]   row_on;
  logic [ROW_W-1:0]  row_idx;
  logic              wr_lo;
  logic              wr_hi;
  logic [DATA_W-1:0] rdata_q;

  // All three selects low enables a row
  for (genvar r = 0; r < ROWS; r++) begin : g_row
    assign row_on[r] = ~mem.row_select_first_n[r] & ~mem.row_select_second_n[r]
                     & ~mem.row_strobe_third_n[r];
  end

  always_comb begin
    row_idx = '0;
    for (int r = 0; r < ROWS; r++) begin
      if (row_on[r]) begin
        row_idx = ROW_W'(r);
      end
    end
  end

  // Either replicated enable writes its byte; a single stuck driver still works
  assign wr_lo = ~(mem.low_byte_wr_out_a_n & mem.low_byte_wr_out_b_n);
  assign wr_hi = ~(mem.high_byte_wr_out_a_n & mem.high_byte_wr_out_b_n);

  always_ff @(posedge i_clk_sys) begin
    if (|row_on) begin
      if (wr_lo) begin
        words[{row_idx, mem.col}][LO_W-1:0] <= mem.wdata[LO_W-1:0];
      end
      if (wr_hi) begin
        words[{row_idx, mem.col}][DATA_W-1:LO_W] <= mem.wdata[DATA_W-1:LO_W];
      end
      rdata_q <= words[{row_idx, mem.col}];
    end
  end

  assign mem.sense_data = rdata_q;
endmodule : bmrs_matrix
`default_nettype wire

// ==== tb/bmrs_top_sva.sv ====
// Port-level assertions for the range select and matrix block
`timescale 1ns/10ps
`default_nettype none
module bmrs_top_sva (
  input wire logic        i_clk_sys,
  input wire logic        i_resetn,
  input wire logic        i_byte,
  input wire logic [17:0] i_bus_addr,
  input wire logic [4:0]  i_range_strap,
  input wire logic [3:0]  i_module_strap,
  input wire logic        i_mos_strap,
  input wire logic        o_range_hit_n,
  input wire logic        o_chip_select_strobe_n,
  input wire logic        o_low_byte_write_strobe_n,
  input wire logic        o_high_byte_write_strobe_n,
  input wire logic        o_refresh_enable,
  input wire logic        o_cycle_done
);
  import bmrs_pkg::*;
  logic lo_n, hi_n, wr, hit;
  assign lo_n = o_low_byte_write_strobe_n;
  assign hi_n = o_high_byte_write_strobe_n;
  assign wr   = !lo_n || !hi_n;
  // Raw straps stand for their synced copies: they only move while idle
  assign hit  = &(i_bus_addr[17:15] ^ i_range_strap[4:2]) && (i_mos_strap ?
                !i_module_strap[i_bus_addr[14:13]] : (&(i_bus_addr[14:13] ^ i_range_strap[1:0])
                && !i_module_strap[i_bus_addr[12:11]]));
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  a_hit_addr: assert property ($fell(o_range_hit_n) |-> hit)
    else $error("hit off range");
  a_cs_with_hit: assert property ($fell(o_chip_select_strobe_n) |-> $fell(o_range_hit_n))
    else $error("select without hit");
  a_strobe_after_cs: assert property (wr |-> $past(!o_chip_select_strobe_n))
    else $error("strobe before select");
  a_strobe_pulse: assert property (wr |=> lo_n && hi_n)
    else $error("strobe too long");
  a_word_both: assert property (wr && !i_byte |-> !lo_n && !hi_n)
    else $error("word strobe missing");
  a_byte_half: assert property (wr && i_byte |-> lo_n == i_bus_addr[0] && hi_n != i_bus_addr[0])
    else $error("wrong byte strobe");
  a_write_in_hit: assert property (wr |-> !o_range_hit_n && $stable(o_range_hit_n))
    else $error("write outside hit");
  a_done_rise: assert property ($rose(o_range_hit_n) |-> o_cycle_done)
    else $error("hit ends without done");
  a_refresh_off: assert property (!i_mos_strap [*5] |-> !o_refresh_enable)
    else $error("refresh on for bipolar");
  a_refresh_on: assert property (i_mos_strap [*5] |-> o_refresh_enable)
    else $error("refresh off for mos");
  c_word: cover property (!lo_n && !hi_n);
  c_byte: cover property (wr && i_byte);
  c_end: cover property ($rose(o_range_hit_n));
endmodule : bmrs_top_sva
bind bmrs_top bmrs_top_sva i_bmrs_top_sva (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
  .i_byte(i_byte), .i_bus_addr(i_bus_addr), .i_range_strap(i_range_strap),
  .i_module_strap(i_module_strap), .i_mos_strap(i_mos_strap), .o_range_hit_n(o_range_hit_n),
  .o_chip_select_strobe_n(o_chip_select_strobe_n), .o_cycle_done(o_cycle_done),
  .o_low_byte_write_strobe_n(o_low_byte_write_strobe_n), .o_refresh_enable(o_refresh_enable),
  .o_high_byte_write_strobe_n(o_high_byte_write_strobe_n));
`default_nettype wire

// ==== tb/bmrs_master.sv ====
// Behavioural processor-side master issuing read and write cycles
`timescale 1ns/10ps
`default_nettype none
module bmrs_master (
  input  wire logic        i_clk_sys,
  input  wire logic        i_range_hit_n,
  input  wire logic        i_chip_select_strobe_n,
  input  wire logic        i_low_byte_write_strobe_n,
  input  wire logic        i_high_byte_write_strobe_n,
  input  wire logic        i_cycle_done,
  output logic             o_cycle_req,
  output logic             o_dato,
  output logic             o_byte,
  output logic [17:0]      o_bus_addr,
  output logic [17:0]      o_wdata,
  output logic [4:0]       o_seen
);
  initial begin
    {o_cycle_req, o_dato, o_byte, o_bus_addr, o_wdata, o_seen} = '0;
  end
  // Flags seen: done, hit, select, low strobe, high strobe
  task automatic run(input logic d, input logic b, input logic [17:0] a, input logic [17:0] w);
    int n;
    @(negedge i_clk_sys);
    {o_dato, o_byte, o_bus_addr, o_wdata, o_seen} = {d, b, a, w, 5'h00};
    repeat (2) @(negedge i_clk_sys);
    o_cycle_req = 1'h1;
    for (n = 0; n < 10; n++) begin
      @(negedge i_clk_sys);
      o_seen[3:0] |= ~{i_range_hit_n, i_chip_select_strobe_n, i_low_byte_write_strobe_n,
                       i_high_byte_write_strobe_n};
    end
    o_cycle_req = 1'h0;
    for (n = 0; n < 12 && !o_seen[4]; n++) begin
      @(negedge i_clk_sys);
      o_seen[4] = (i_cycle_done === 1'h1);
    end
    // Released lines flip so a stale value can never pass as held
    {o_bus_addr, o_wdata} = ~{o_bus_addr, o_wdata};
  endtask : run
endmodule : bmrs_master
`default_nettype wire

// ==== tb/bmrs_top_bench.sv ====
// Self-checking bench for the range select and matrix block
`timescale 1ns/10ps
`default_nettype none
module bmrs_top_bench;
  import bmrs_pkg::*;
  logic        clk = 1'h0;
  logic        rstn = 1'h0;
  logic        mos = 1'h0;
  logic [4:0]  rstrap = 5'h14;
  logic [3:0]  mstrap = 4'h2;
  logic        req, dato, byt, hit_n, cs_n, lo_n, hi_n, refr, done;
  logic [17:0] addr, wd, sense;
  logic [4:0]  seen;
  int          n_mismatch = 0;
  int          checked = 0;
  int          cycles = 0;
  always #4 clk = ~clk;
  bmrs_top i_bmrs_top (.i_clk_sys(clk), .i_resetn(rstn), .i_cycle_req(req), .i_dato(dato),
    .i_byte(byt), .i_bus_addr(addr), .i_wdata(wd), .i_range_strap(rstrap),
    .i_module_strap(mstrap), .i_mos_strap(mos), .o_range_hit_n(hit_n),
    .o_chip_select_strobe_n(cs_n), .o_low_byte_write_strobe_n(lo_n),
    .o_high_byte_write_strobe_n(hi_n), .o_refresh_enable(refr), .o_cycle_done(done),
    .o_sense_data(sense));
  bmrs_master i_bmrs_master (.i_clk_sys(clk), .i_range_hit_n(hit_n),
    .i_chip_select_strobe_n(cs_n), .i_low_byte_write_strobe_n(lo_n),
    .i_high_byte_write_strobe_n(hi_n), .i_cycle_done(done), .o_cycle_req(req),
    .o_dato(dato), .o_byte(byt), .o_bus_addr(addr), .o_wdata(wd), .o_seen(seen));
  task automatic chk(input string what, input logic [17:0] got, input logic [17:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Straps accept bits 17..13 = 01011 and refuse quarter 1
  function automatic logic [17:0] ad(input logic [1:0] q, input logic [1:0] r, input logic [7:0] c);
    return {5'h0B, q, r, c, 1'h0};
  endfunction : ad
  task automatic wr(input logic b, input logic [17:0] a, input logic [17:0] w);
    i_bmrs_master.run(1'h1, b, a, w);
  endtask : wr
  task automatic t_rows;
    for (int r = 0; r < 4; r++) begin
      wr(1'h0, ad(2'h0, 2'(r), 8'(r * 85)), {2'(r), 16'hA5C3});
      chk("word flags", {13'h0, seen}, 18'h1F);
    end
    for (int r = 3; r >= 0; r--) begin
      i_bmrs_master.run(1'h0, 1'h0, ad(2'h0, 2'(r), 8'(r * 85)), 18'h0);
      chk("read flags", {13'h0, seen}, 18'h1C);
      chk("row data", sense, {2'(r), 16'hA5C3});
    end
  endtask : t_rows
  task automatic t_bytes;
    wr(1'h0, ad(2'h3, 2'h2, 8'h10), 18'h00000);
    wr(1'h1, ad(2'h3, 2'h2, 8'h10), 18'h3FFFF);
    chk("low byte flags", {13'h0, seen}, 18'h1E);
    wr(1'h1, ad(2'h3, 2'h2, 8'h10) | 18'h1, 18'h2AA00);
    chk("high byte flags", {13'h0, seen}, 18'h1D);
    i_bmrs_master.run(1'h0, 1'h0, ad(2'h3, 2'h2, 8'h10), 18'h0);
    chk("byte merge", sense, 18'h2ABFF);
  endtask : t_bytes
  task automatic t_miss;
    for (int b = 0; b < 5; b++) begin
      wr(1'h0, ad(2'h0, 2'h1, 8'h33) ^ (18'h2000 << b), 18'h3FFFF);
      chk("range miss flags", {13'h0, seen}, 18'h10);
    end
    for (int i = 0; i < 4; i++) begin
      wr(1'h0, ad(2'(i + 2), 2'h1, 8'h33), {2'(i + 2), 16'h0F0F});
      chk("module flags", {13'h0, seen}, (i == 3) ? 18'h10 : 18'h1F);
    end
    i_bmrs_master.run(1'h0, 1'h0, ad(2'h0, 2'h1, 8'h33), 18'h0);
    chk("refused write", sense, 18'h00F0F);
  endtask : t_miss
  // MOS strap: bits 14..13 steer the module terms and leave the range compare
  task automatic t_mos;
    mos = 1'h1;
    repeat (6) @(negedge clk);
    chk("refresh on", {17'h0, refr}, 18'h1);
    wr(1'h0, {5'h08, 2'h1, 2'h2, 8'h44, 1'h0}, 18'h1B4E1);
    chk("mos word flags", {13'h0, seen}, 18'h1F);
    wr(1'h0, {5'h09, 2'h0, 2'h2, 8'h44, 1'h0}, 18'h3FFFF);
    chk("mos refused flags", {13'h0, seen}, 18'h10);
    i_bmrs_master.run(1'h0, 1'h0, {5'h08, 2'h3, 2'h2, 8'h44, 1'h0}, 18'h0);
    chk("mos read flags", {13'h0, seen}, 18'h1C);
    chk("mos read", sense, 18'h1B4E1);
    mos = 1'h0;
    repeat (6) @(negedge clk);
    chk("refresh off", {17'h0, refr}, 18'h0);
  endtask : t_mos
  // Moved straps: range 10100 accepted, quarters 0 and 3 refused
  task automatic t_straps;
    rstrap = 5'h0B;
    mstrap = 4'h9;
    wr(1'h0, {5'h14, 2'h1, 2'h0, 8'h5A, 1'h0}, 18'h2C3A5);
    chk("new range flags", {13'h0, seen}, 18'h1F);
    wr(1'h0, {5'h14, 2'h0, 2'h0, 8'h5A, 1'h0}, 18'h3FFFF);
    chk("new quarter flags", {13'h0, seen}, 18'h10);
    wr(1'h0, {5'h0B, 2'h1, 2'h0, 8'h5A, 1'h0}, 18'h3FFFF);
    chk("old range flags", {13'h0, seen}, 18'h10);
    i_bmrs_master.run(1'h0, 1'h0, {5'h14, 2'h2, 2'h0, 8'h5A, 1'h0}, 18'h0);
    chk("new range read", sense, 18'h2C3A5);
  endtask : t_straps
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'h1;
    repeat (4) @(negedge clk);
    chk("idle outputs", {12'h0, hit_n, cs_n, lo_n, hi_n, refr, done}, 18'h3C);
    chk("idle sense", sense, 18'h0);
    t_rows();
    t_bytes();
    t_miss();
    t_mos();
    t_straps();
    complete_run();
  end
endmodule : bmrs_top_bench
`default_nettype wire
